// ### hdl/gecnt_pkg.sv
// Package for the gated event counter: offsets, fields, modes and timing
package gecnt_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] DIV_OFS     = 4'h4;
    localparam logic [3:0] COUNT_OFS   = 4'h8;
    localparam logic [3:0] STATUS_OFS  = 4'hC;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_GATE_LSB  = 0;
    localparam int CTRL_EDGE_BIT  = 4;
    localparam int CTRL_TB_BIT    = 5;
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_STOP_BIT  = 9;
    localparam int CTRL_CLR_BIT   = 10;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DIV_RESET  = 32'h0000_0001;
    localparam logic [31:0] CNT_RESET  = 32'h0000_0000;

    // ****************************************
    // Modes and states
    // ****************************************
    typedef enum logic [2:0] {
        GECNT_GATE_NONE = 3'h0,
        GECNT_GATE_HIGH = 3'h1,
        GECNT_GATE_LOW  = 3'h2,
        GECNT_GATE_RISE = 3'h3,
        GECNT_GATE_FALL = 3'h4
    } gecnt_gate_t;

    typedef enum logic [1:0] {
        GECNT_IDLE  = 2'b00,
        GECNT_ARMED = 2'b01,
        GECNT_RUN   = 2'b11
    } gecnt_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } gecnt_bus_t;

    typedef struct packed {
        gecnt_gate_t gate_mode;
        logic        edge_fall;
        logic        use_timebase;
    } gecnt_cfg_t;

    localparam int SYNC_STAGES = 2;

endpackage

// ### hdl/gecnt_edge.sv
// Pin synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module gecnt_edge (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~prev_ff;
    assign fall  = ~sync_ff & prev_ff;

endmodule

// ### hdl/gecnt_top.sv
// Gated event counter: register port, gate control and event accumulation
//
// Contract
// - Each qualifying transition on the event source pin counts as one event.
// - Gate mode 0 ignores the gate and counts right after the start command.
// - Gate mode 1 counts only while the gate is high after start.
// - Gate mode 2 counts only while the gate is low after start.
// - Gate mode 3 waits after start for a gate rising edge, then counts.
// - Gate mode 4 waits after start for a gate falling edge, then counts.
// - Source edge 0 counts rising transitions and 1 counts falling ones.
// - The timebase setting selects internal timebase cycles or source pin edges.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module gecnt_top #(
    parameter int CNT_W = 32
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        event_source_pin,
    input  wire logic        count_gate_pin,
    output logic             counting
);

    // ****************************************
    // Declarations
    // ****************************************
    gecnt_pkg::gecnt_bus_t   bus;
    gecnt_pkg::gecnt_cfg_t   cfg_ff;
    gecnt_pkg::gecnt_state_t state_ff;
    gecnt_pkg::gecnt_state_t nxt_state;
    logic [31:0]      div_ff;
    logic [31:0]      tb_cnt_ff;
    logic             tb_tick;
    logic [CNT_W-1:0] count_ff;
    logic [31:0]      rdata_ff;
    logic             counting_ff;
    logic             src_lvl, src_rise, src_fall;
    logic             gate_lvl, gate_rise, gate_fall;
    logic             start_cmd, stop_cmd, clr_cmd;
    logic             src_evt;
    logic             gate_ok;
    logic             cnt_en;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    gecnt_edge u_src (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin      (event_source_pin),
        .level    (src_lvl),
        .rise     (src_rise),
        .fall     (src_fall)
    );

    gecnt_edge u_gate (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin      (count_gate_pin),
        .level    (gate_lvl),
        .rise     (gate_rise),
        .fall     (gate_fall)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic gecnt_pkg::gecnt_gate_t mode_of(input logic [31:0] d);
        if (d[gecnt_pkg::CTRL_GATE_LSB +: 3] > 3'h4) begin
            mode_of = gecnt_pkg::GECNT_GATE_NONE;
        end else begin
            mode_of = gecnt_pkg::gecnt_gate_t'(d[gecnt_pkg::CTRL_GATE_LSB +: 3]);
        end
    endfunction

    // ****************************************
    // Configuration and commands
    // ****************************************
    assign start_cmd = bus.wr && hit(bus.addr, gecnt_pkg::CTRL_OFS)
                       && bus.wdata[gecnt_pkg::CTRL_START_BIT];
    assign stop_cmd  = bus.wr && hit(bus.addr, gecnt_pkg::CTRL_OFS)
                       && bus.wdata[gecnt_pkg::CTRL_STOP_BIT];
    assign clr_cmd   = bus.wr && hit(bus.addr, gecnt_pkg::CTRL_OFS)
                       && bus.wdata[gecnt_pkg::CTRL_CLR_BIT];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= gecnt_pkg::gecnt_cfg_t'(5'h00);
        end else if (bus.wr && hit(bus.addr, gecnt_pkg::CTRL_OFS)) begin
            cfg_ff.gate_mode    <= mode_of(bus.wdata);
            cfg_ff.edge_fall    <= bus.wdata[gecnt_pkg::CTRL_EDGE_BIT];
            cfg_ff.use_timebase <= bus.wdata[gecnt_pkg::CTRL_TB_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= gecnt_pkg::DIV_RESET;
        end else if (bus.wr && hit(bus.addr, gecnt_pkg::DIV_OFS)) begin
            div_ff <= (bus.wdata == 32'h0000_0000) ? 32'h0000_0001 : bus.wdata;
        end
    end

    // ****************************************
    // Internal timebase divider
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_cnt_ff <= 32'h0000_0000;
        end else if (tb_tick) begin
            tb_cnt_ff <= 32'h0000_0000;
        end else begin
            tb_cnt_ff <= tb_cnt_ff + 32'h0000_0001;
        end
    end

    assign tb_tick = (tb_cnt_ff >= div_ff - 32'h0000_0001);

    // Timebase ticks or selected source transition
    always_comb begin
        if (cfg_ff.use_timebase) begin
            src_evt = tb_tick;
        end else if (cfg_ff.edge_fall) begin
            src_evt = src_fall;
        end else begin
            src_evt = src_rise;
        end
    end

    // ****************************************
    // Gate state machine
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            gecnt_pkg::GECNT_IDLE: begin
                // Start obeys the gate mode written in the same word
                if (start_cmd) begin
                    if (mode_of(bus.wdata) == gecnt_pkg::GECNT_GATE_RISE ||
                        mode_of(bus.wdata) == gecnt_pkg::GECNT_GATE_FALL) begin
                        nxt_state = gecnt_pkg::GECNT_ARMED;
                    end else begin
                        nxt_state = gecnt_pkg::GECNT_RUN;
                    end
                end
            end
            gecnt_pkg::GECNT_ARMED: begin
                if ((cfg_ff.gate_mode == gecnt_pkg::GECNT_GATE_RISE && gate_rise) ||
                    (cfg_ff.gate_mode == gecnt_pkg::GECNT_GATE_FALL && gate_fall)) begin
                    nxt_state = gecnt_pkg::GECNT_RUN;
                end
            end
            default: begin
                nxt_state = state_ff;
            end
        endcase
        if (stop_cmd) begin
            nxt_state = gecnt_pkg::GECNT_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= gecnt_pkg::GECNT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        case (cfg_ff.gate_mode)
            gecnt_pkg::GECNT_GATE_HIGH: gate_ok = gate_lvl;
            gecnt_pkg::GECNT_GATE_LOW:  gate_ok = ~gate_lvl;
            default:                    gate_ok = 1'b1;
        endcase
    end

    assign cnt_en = (state_ff == gecnt_pkg::GECNT_RUN) && gate_ok;

    // ****************************************
    // Event accumulator
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= CNT_W'(gecnt_pkg::CNT_RESET);
        end else if (clr_cmd) begin
            count_ff <= CNT_W'(gecnt_pkg::CNT_RESET);
        end else if (cnt_en && src_evt) begin
            count_ff <= count_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            counting_ff <= 1'b0;
        end else begin
            counting_ff <= (nxt_state == gecnt_pkg::GECNT_RUN);
        end
    end

    assign counting = counting_ff;

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus.rd) begin
            if (hit(bus.addr, gecnt_pkg::CTRL_OFS)) begin
                rdata_ff <= {26'h0, cfg_ff.use_timebase, cfg_ff.edge_fall,
                             1'b0, cfg_ff.gate_mode};
            end else if (hit(bus.addr, gecnt_pkg::DIV_OFS)) begin
                rdata_ff <= div_ff;
            end else if (hit(bus.addr, gecnt_pkg::COUNT_OFS)) begin
                rdata_ff <= 32'(count_ff);
            end else if (hit(bus.addr, gecnt_pkg::STATUS_OFS)) begin
                rdata_ff <= {28'h0, gate_lvl, src_lvl, state_ff};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;

    // ****************************************
    // Checks
    // ****************************************
    property p_cnt_step;
        @(posedge core_clk) disable iff (!rst_b)
        (cnt_en && src_evt && !clr_cmd) |=> (count_ff == $past(count_ff) + CNT_W'(1));
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count did not step");

    property p_cnt_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (!(cnt_en && src_evt) && !clr_cmd) |=> $stable(count_ff);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved while idle");

    property p_mode0_start;
        @(posedge core_clk) disable iff (!rst_b)
        (state_ff == gecnt_pkg::GECNT_IDLE && start_cmd && !stop_cmd &&
         mode_of(bus.wdata) == gecnt_pkg::GECNT_GATE_NONE)
        |=> (state_ff == gecnt_pkg::GECNT_RUN) && cnt_en;
    endproperty
    a_mode0_start: assert property (p_mode0_start) else $error("mode 0 not running");

    property p_high_gate;
        @(posedge core_clk) disable iff (!rst_b)
        (cfg_ff.gate_mode == gecnt_pkg::GECNT_GATE_HIGH && !gate_lvl) |-> !cnt_en;
    endproperty
    a_high_gate: assert property (p_high_gate) else $error("counted with gate low");

    property p_low_gate;
        @(posedge core_clk) disable iff (!rst_b)
        (cfg_ff.gate_mode == gecnt_pkg::GECNT_GATE_LOW && gate_lvl) |-> !cnt_en;
    endproperty
    a_low_gate: assert property (p_low_gate) else $error("counted with gate high");

    property p_rise_arm;
        @(posedge core_clk) disable iff (!rst_b)
        (state_ff == gecnt_pkg::GECNT_ARMED && !stop_cmd &&
         cfg_ff.gate_mode == gecnt_pkg::GECNT_GATE_RISE && gate_rise)
        |=> state_ff == gecnt_pkg::GECNT_RUN;
    endproperty
    a_rise_arm: assert property (p_rise_arm) else $error("rise edge not taken");

    property p_fall_arm;
        @(posedge core_clk) disable iff (!rst_b)
        (state_ff == gecnt_pkg::GECNT_ARMED && !gate_fall && !stop_cmd &&
         cfg_ff.gate_mode == gecnt_pkg::GECNT_GATE_FALL)
        |=> state_ff == gecnt_pkg::GECNT_ARMED;
    endproperty
    a_fall_arm: assert property (p_fall_arm) else $error("left armed early");

    property p_edge_sel;
        @(posedge core_clk) disable iff (!rst_b)
        (!cfg_ff.use_timebase && cfg_ff.edge_fall) |-> (src_evt == src_fall);
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("wrong source edge");

    property p_src_count;
        @(posedge core_clk) disable iff (!rst_b)
        (!cfg_ff.use_timebase && !cfg_ff.edge_fall && cnt_en && !clr_cmd &&
         $rose(src_lvl)) |=> count_ff == $past(count_ff) + CNT_W'(1);
    endproperty
    a_src_count: assert property (p_src_count) else $error("source edge lost");

    property p_tb_sel;
        @(posedge core_clk) disable iff (!rst_b)
        cfg_ff.use_timebase |-> (src_evt == tb_tick);
    endproperty
    a_tb_sel: assert property (p_tb_sel) else $error("timebase not selected");

endmodule

// ### testbench/gecnt_pin_model.sv
// Model of the external event source and gate signals driving the counter pins
`timescale 1ns/1ps
module gecnt_pin_model (
    input  wire logic core_clk,
    output logic      src,
    output logic      gate
);

    // ****************************************
    // Pin drivers
    // ****************************************
    initial begin
        src  = 1'b0;
        gate = 1'b0;
    end

    // Each level stands 4 cycles so the synchroniser cannot miss it
    task automatic src_level(input logic v);
        @(posedge core_clk);
        src <= v;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic src_pulses(input int n);
        repeat (n) begin
            src_level(1'b1);
            src_level(1'b0);
        end
    endtask

    task automatic gate_level(input logic v);
        @(posedge core_clk);
        gate <= v;
        repeat (3) @(posedge core_clk);
    endtask

endmodule

// ### testbench/tb_gated_event_counter.sv
// Self-checking testbench for the gated event counter
`timescale 1ns/1ps
module tb_gated_event_counter;

    logic        core_clk;
    logic        rst_b;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        src;
    logic        gate;
    logic        counting;
    logic [31:0] rd_val;
    int          mismatches;
    int          num_checks;

    gecnt_top #(.CNT_W(32)) gecnt_top_inst (
        .core_clk         (core_clk),
        .rst_b            (rst_b),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .event_source_pin (src),
        .count_gate_pin   (gate),
        .counting         (counting)
    );

    gecnt_pin_model gecnt_pin_model_inst (
        .core_clk (core_clk),
        .src      (src),
        .gate     (gate)
    );

    // ****************************************
    // Common tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic cnt_is(input logic [31:0] exp);
        repeat (3) @(posedge core_clk);
        reg_read(gecnt_pkg::COUNT_OFS);
        check(rd_val, exp);
    endtask

    // Stop and clear, then start with the given configuration
    task automatic restart(input logic [31:0] cfg);
        reg_write(gecnt_pkg::CTRL_OFS, cfg | 32'h0000_0600);
        reg_write(gecnt_pkg::CTRL_OFS, cfg | 32'h0000_0100);
    endtask

    // Pin stimulus through the partner model
    task automatic pulses(input int n);
        gecnt_pin_model_inst.src_pulses(n);
    endtask

    task automatic src_to(input logic v);
        gecnt_pin_model_inst.src_level(v);
    endtask

    task automatic gate_to(input logic v);
        gecnt_pin_model_inst.gate_level(v);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        reg_read(gecnt_pkg::CTRL_OFS);
        check(rd_val, gecnt_pkg::CTRL_RESET);
        reg_read(gecnt_pkg::DIV_OFS);
        check(rd_val, gecnt_pkg::DIV_RESET);
        @(posedge core_clk);
        #1;
        check(reg_rdata, 32'h0000_0000);
        reg_read(gecnt_pkg::COUNT_OFS);
        check(rd_val, gecnt_pkg::CNT_RESET);
        reg_read(gecnt_pkg::STATUS_OFS);
        check(rd_val, 32'h0000_0000);
        reg_read(4'h2);
        check(rd_val, 32'h0000_0000);
        check({31'h0, counting}, 32'h0000_0000);
        reg_write(gecnt_pkg::CTRL_OFS, 32'h0000_0037);
        reg_read(gecnt_pkg::CTRL_OFS);
        check(rd_val, 32'h0000_0030);
        reg_write(gecnt_pkg::CTRL_OFS, 32'h0000_0000);
    endtask

    task automatic t_free;
        pulses(2);
        cnt_is(32'h0000_0000);
        restart(32'h0000_0000);
        #1;
        check({31'h0, counting}, 32'h0000_0001);
        gate_to(1'b1);
        pulses(3);
        gate_to(1'b0);
        pulses(1);
        cnt_is(32'h0000_0004);
        reg_write(gecnt_pkg::CTRL_OFS, 32'h0000_0200);
        pulses(1);
        cnt_is(32'h0000_0004);
    endtask

    task automatic t_edge;
        restart(32'h0000_0010);
        src_to(1'b1);
        cnt_is(32'h0000_0000);
        src_to(1'b0);
        cnt_is(32'h0000_0001);
        restart(32'h0000_0000);
        src_to(1'b1);
        cnt_is(32'h0000_0001);
        src_to(1'b0);
        cnt_is(32'h0000_0001);
    endtask

    // Level gating: counts only while the gate sits at the active level
    task automatic t_level(input logic [31:0] cfg, input logic on);
        gate_to(!on);
        restart(cfg);
        pulses(2);
        cnt_is(32'h0000_0000);
        gate_to(on);
        pulses(2);
        cnt_is(32'h0000_0002);
        gate_to(!on);
        pulses(1);
        cnt_is(32'h0000_0002);
    endtask

    // Edge start: armed until the gate edge, then counts regardless of gate
    task automatic t_trig(input logic [31:0] cfg, input logic on);
        gate_to(!on);
        restart(cfg);
        reg_read(gecnt_pkg::STATUS_OFS);
        check(rd_val, on ? 32'h0000_0001 : 32'h0000_0009);
        check({31'h0, counting}, 32'h0000_0000);
        pulses(1);
        cnt_is(32'h0000_0000);
        gate_to(on);
        repeat (3) @(posedge core_clk);
        check({31'h0, counting}, 32'h0000_0001);
        pulses(2);
        gate_to(!on);
        pulses(1);
        cnt_is(32'h0000_0003);
    endtask

    // Reset while running brings every register back to its reset value
    task automatic t_mid_reset;
        gate_to(1'b0);
        restart(32'h0000_0000);
        pulses(2);
        cnt_is(32'h0000_0002);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
    endtask

    task automatic t_timebase;
        reg_write(gecnt_pkg::DIV_OFS, 32'h0000_0000);
        reg_read(gecnt_pkg::DIV_OFS);
        check(rd_val, 32'h0000_0001);
        reg_write(gecnt_pkg::DIV_OFS, 32'h0000_0005);
        reg_read(gecnt_pkg::DIV_OFS);
        check(rd_val, 32'h0000_0005);
        restart(32'h0000_0020);
        pulses(6);
        reg_write(gecnt_pkg::CTRL_OFS, 32'h0000_0220);
        reg_read(gecnt_pkg::COUNT_OFS);
        check(rd_val, 32'h0000_000A);
    endtask

    // ****************************************
    // Clock, reset, sequence and watchdog
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        rst_b      = 1'b0;
        reg_addr   = 4'h0;
        reg_wdata  = 32'h0000_0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        mismatches = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_free();
        t_edge();
        t_level(32'h0000_0001, 1'b1);
        t_level(32'h0000_0002, 1'b0);
        t_trig(32'h0000_0003, 1'b1);
        t_trig(32'h0000_0004, 1'b0);
        t_timebase();
        t_mid_reset();
        results();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        results();
    end

endmodule
